// *** strap_config_and_register_map.sv ***
module strap_config_and_register_map
    import strap_regmap_pkg::*;
#(
    parameter logic [15:0] DEVICE_ID = 16'h0a5c  // arbitrary value
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hostCsN,
    input wire logic hostRdN,
    input wire logic hostWrN,
    input wire logic [ADDR_W-1:0] hostAddr,
    input wire logic [DATA_W-1:0] hostDataIn,
    output logic [DATA_W-1:0] hostDataOut,
    output logic hostDataOe,
    input wire logic strap_config_enable,
    input wire logic [1:0] profileSelect,
    input wire logic reduced_interface_select,
    input wire logic line_role_select,
    input wire logic full_duplex_strap,
    input wire logic laps_encap_enable,
    input wire logic scrambler_bypass,
    input wire logic bit_order_reverse,
    input wire logic [7:0] lineClockActivity,
    input wire logic [7:0] refSysClockActivity,
    input wire logic [7:0] lineEvents,
    input wire logic [7:0] subscriberEvents,
    input wire logic [7:0] queueEvents,
    input wire logic [7:0] bertEvents,
    input wire logic [1:0] selfTestResult,
    input wire logic [7:0] macReadData,
    input wire logic macReadValid,
    output logic cfgStrapped,
    output logic cfgLapsEncap,
    output logic cfgScramblerBypass,
    output logic cfgBitOrderReverse,
    output logic cfgReducedInterface,
    output logic cfgLineRoleDce,
    output logic cfgFullDuplex,
    output logic [7:0] cfgTxQueueSize,
    output logic [7:0] cfgRxQueueSize,
    output logic softReset,
    output logic [7:0] globalControl,
    output logic macReq,
    output logic macWrite,
    output logic [15:0] macAddr,
    output logic [7:0] macWrData
);
    // two-stage synchroniser for every host bus and strap pin; only stage two is read
    logic [SYNC_W-1:0] pinSync1_q;
    logic [SYNC_W-1:0] pinSync2_q;
    wire [SYNC_W-1:0] pinRaw = {hostCsN, hostRdN, hostWrN, hostAddr, hostDataIn, strap_config_enable,
        profileSelect, reduced_interface_select, line_role_select, full_duplex_strap,
        laps_encap_enable, scrambler_bypass, bit_order_reverse};

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pinSync1_q <= '1;
            pinSync2_q <= '1;
        end
        else
        begin
            pinSync1_q <= pinRaw;
            pinSync2_q <= pinSync1_q;
        end
    end

    wire csN = pinSync2_q[SYNC_W-1];
    wire rdN = pinSync2_q[SYNC_W-2];
    wire wrN = pinSync2_q[SYNC_W-3];
    wire [ADDR_W-1:0] addr = pinSync2_q[SYNC_W-4 -: ADDR_W];
    wire [DATA_W-1:0] wrData = pinSync2_q[SYNC_W-4-ADDR_W -: DATA_W];
    wire strapEnable = pinSync2_q[8];
    wire [1:0] strapProfile = pinSync2_q[7:6];
    wire [4:0] strapCfg = {pinSync2_q[4], pinSync2_q[5], pinSync2_q[0], pinSync2_q[1], pinSync2_q[2]};
    wire strapDuplex = pinSync2_q[3];

    // strobe edge detection on synchronised levels
    logic rdActive_q;
    logic wrActive_q;
    wire rdActive = !csN && !rdN;
    wire wrActive = !csN && !wrN;
    wire rdStart = rdActive && !rdActive_q;
    wire wrStart = wrActive && !wrActive_q;

    // section decode from the top four address lines, 64-byte sections
    wire [ADDR_W-1:0] section = addr & SEC_MASK;
    wire [5:0] ofs = addr[5:0];
    wire inGlobal = section == SEC_GLOBAL;
    wire inArbiter = section == SEC_ARBITER;
    wire inEthernet = section == SEC_ETHERNET;

    // writable bits of each global location; reserved bits never store
    function automatic logic [7:0] globalWriteMask(input logic [5:0] o);
        case (o)
            OFS_GLOBAL_CONTROL_ONE: globalWriteMask = MASK_CONTROL_ONE;
            OFS_GLOBAL_BANK_LATCH: globalWriteMask = MASK_BIT0;
            OFS_LINE_IRQ_ENABLE: globalWriteMask = MASK_BITS_4_0;
            OFS_SUBSCRIBER_IRQ_ENABLE: globalWriteMask = MASK_BIT0;
            OFS_QUEUE_IRQ_ENABLE: globalWriteMask = MASK_BITS_4_0;
            OFS_BERT_IRQ_ENABLE: globalWriteMask = MASK_BIT0;
            OFS_GLOBAL_CONNECTION: globalWriteMask = MASK_BIT0;
            OFS_QUEUE_PRIORITY_CONTROL: globalWriteMask = MASK_PRIORITY;
            OFS_STRAP_SHADOW_CONFIG: globalWriteMask = MASK_SHADOW;
            OFS_SELF_TEST_ENABLE: globalWriteMask = MASK_BIT0;
            OFS_SDRAM_MODE_ONE: globalWriteMask = MASK_SDRAM_ONE;
            OFS_SDRAM_MODE_TWO: globalWriteMask = MASK_SDRAM_TWO;
            OFS_SDRAM_MODE_WRITE_STROBE: globalWriteMask = MASK_BIT0;
            OFS_SDRAM_REFRESH_COUNT: globalWriteMask = MASK_ALL;
            default: globalWriteMask = RESET_BYTE;
        endcase
    endfunction

    // writable global storage, masked when written and read back as stored except the strap shadow in strapped mode
    logic [7:0] globalRegs_q [SEC_DEPTH];
    logic [7:0] rxQueueReg_q;
    logic [7:0] txQueueReg_q;
    wire [7:0] wrMask = globalWriteMask(ofs);
    wire globalWrite = wrStart && inGlobal;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < SEC_DEPTH; i++)
            begin
                globalRegs_q[i] <= RESET_BYTE;
            end
        end
        else if (globalWrite)
        begin
            globalRegs_q[ofs] <= wrData & wrMask;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rxQueueReg_q <= RESET_BYTE;
            txQueueReg_q <= RESET_BYTE;
        end
        else if (wrStart && inArbiter)
        begin
            if (ofs == OFS_RX_QUEUE_SIZE)
                rxQueueReg_q <= wrData;
            if (ofs == OFS_TX_QUEUE_SIZE)
                txQueueReg_q <= wrData;
        end
    end

    // latched status: set on event, cleared by the read that returns it
    logic [7:0] lineStatus_q;
    logic [7:0] subStatus_q;
    logic [7:0] queueStatus_q;
    logic [7:0] bertStatus_q;
    wire clrLine = rdStart && inGlobal && ofs == OFS_LINE_IRQ_STATUS;
    wire clrSub = rdStart && inGlobal && ofs == OFS_SUBSCRIBER_IRQ_STATUS;
    wire clrQueue = rdStart && inGlobal && ofs == OFS_QUEUE_IRQ_STATUS;
    wire clrBert = rdStart && inGlobal && ofs == OFS_BERT_IRQ_STATUS;

    // an event in the clearing cycle survives: set wins over clear
    function automatic logic [7:0] latchNext(input logic [7:0] cur, input logic clr,
                                             input logic [7:0] ev, input logic [7:0] mask);
        latchNext = ((clr ? RESET_BYTE : cur) | ev) & mask;
    endfunction

    wire [7:0] lineStatus_d = latchNext(lineStatus_q, clrLine, lineEvents, MASK_BITS_4_0);
    wire [7:0] subStatus_d = latchNext(subStatus_q, clrSub, subscriberEvents, MASK_BIT0);
    wire [7:0] queueStatus_d = latchNext(queueStatus_q, clrQueue, queueEvents, MASK_BITS_4_0);
    wire [7:0] bertStatus_d = latchNext(bertStatus_q, clrBert, bertEvents, MASK_BIT0);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            lineStatus_q <= RESET_BYTE;
            subStatus_q <= RESET_BYTE;
            queueStatus_q <= RESET_BYTE;
            bertStatus_q <= RESET_BYTE;
        end
        else
        begin
            lineStatus_q <= lineStatus_d;
            subStatus_q <= subStatus_d;
            queueStatus_q <= queueStatus_d;
            bertStatus_q <= bertStatus_d;
        end
    end

    // indirect mac window; mac space itself has no direct address
    logic [15:0] macAddr_q;
    logic [7:0] macWrData_q;
    logic [7:0] macRdData_q;
    logic macReq_q;
    logic macWrite_q;
    wire ethWrite = wrStart && inEthernet;
    wire macCmd = ethWrite && ofs == OFS_MAC_COMMAND;
    wire [7:0] cmdBits = wrData & MASK_MAC_CMD;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            macAddr_q <= '0;
            macWrData_q <= RESET_BYTE;
            macRdData_q <= RESET_BYTE;
            macReq_q <= 1'b0;
            macWrite_q <= 1'b0;
        end
        else
        begin
            if (ethWrite && ofs == OFS_MAC_ADDR_LOW)
                macAddr_q[7:0] <= wrData;
            if (ethWrite && ofs == OFS_MAC_ADDR_HIGH)
                macAddr_q[15:8] <= wrData;
            if (ethWrite && ofs == OFS_MAC_DATA)
                macWrData_q <= wrData;
            if (macReadValid)
                macRdData_q <= macReadData;
            // one-cycle request; write wins if both command bits are set
            macReq_q <= macCmd && (cmdBits[CMD_WRITE] || cmdBits[CMD_READ]);
            if (macCmd)
                macWrite_q <= cmdBits[CMD_WRITE];
        end
    end

    // straps caught after release, recaught on each entry to strapped mode
    logic [1:0] settle_q;
    logic strapMode_q;
    logic [4:0] strapCfg_q;
    logic [1:0] strapProfile_q;
    logic strapDuplex_q;
    wire settled = settle_q == STRAP_SETTLE;
    wire strapCatch = settled && strapEnable && !strapMode_q;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            settle_q <= 2'h0;
            strapMode_q <= 1'b0;
            strapCfg_q <= '0;
            strapProfile_q <= PROFILE_A;
            strapDuplex_q <= 1'b1;
        end
        else
        begin
            if (!settled)
                settle_q <= settle_q + 2'h1;
            if (settled)
                strapMode_q <= strapEnable;
            if (strapCatch)
            begin
                strapCfg_q <= strapCfg;
                strapProfile_q <= strapProfile;
                strapDuplex_q <= strapDuplex;
            end
        end
    end

    // profile 10 gives the larger tx queue; other codes take profile 00 values
    wire profileB = strapProfile_q == PROFILE_B;
    wire [7:0] strapTxQueue = profileB ? TX_QUEUE_PROFILE_B : TX_QUEUE_PROFILE_A;
    wire [7:0] strapRxQueue = profileB ? RX_QUEUE_PROFILE_B : RX_QUEUE_PROFILE_A;
    wire [4:0] regCfg = globalRegs_q[OFS_STRAP_SHADOW_CONFIG][4:0];
    wire [4:0] effCfg = strapMode_q ? strapCfg_q : regCfg;
    wire [7:0] effTxQueue = strapMode_q ? strapTxQueue : txQueueReg_q;
    wire [7:0] effRxQueue = strapMode_q ? strapRxQueue : rxQueueReg_q;

    // read mux; unlisted locations read as stored, so only unmapped and unused locations read zero
    function automatic logic [7:0] globalRead(input logic [5:0] o);
        case (o)
            OFS_ID_LOW: globalRead = DEVICE_ID[7:0];
            OFS_ID_HIGH: globalRead = DEVICE_ID[15:8];
            OFS_LINE_CLOCK_ACTIVITY: globalRead = lineClockActivity & MASK_BITS_4_0;
            OFS_REF_SYS_CLOCK_ACTIVITY: globalRead = refSysClockActivity & MASK_SELF_TEST;
            OFS_LINE_IRQ_STATUS: globalRead = lineStatus_q;
            OFS_SUBSCRIBER_IRQ_STATUS: globalRead = subStatus_q;
            OFS_QUEUE_IRQ_STATUS: globalRead = queueStatus_q;
            OFS_BERT_IRQ_STATUS: globalRead = bertStatus_q;
            OFS_STRAP_SHADOW_CONFIG: globalRead = {3'h0, effCfg};
            OFS_SELF_TEST_RESULT: globalRead = {6'h00, selfTestResult};
            default: globalRead = globalRegs_q[o];
        endcase
    endfunction

    wire [7:0] arbiterRead = (ofs == OFS_RX_QUEUE_SIZE) ? effRxQueue :
        (ofs == OFS_TX_QUEUE_SIZE) ? effTxQueue : RESET_BYTE;
    wire [7:0] ethernetRead = (ofs == OFS_MAC_ADDR_LOW) ? macAddr_q[7:0] :
        (ofs == OFS_MAC_ADDR_HIGH) ? macAddr_q[15:8] :
        (ofs == OFS_MAC_DATA) ? macWrData_q :
        (ofs == OFS_MAC_READ_DATA) ? macRdData_q : RESET_BYTE;
    wire [7:0] readValue = inGlobal ? globalRead(ofs) :
        inArbiter ? arbiterRead :
        inEthernet ? ethernetRead : RESET_BYTE;

    // read data captured at strobe start and held until strobe ends
    logic [7:0] rdData_q;
    logic rdOe_q;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdActive_q <= 1'b0;
            wrActive_q <= 1'b0;
            rdData_q <= RESET_BYTE;
            rdOe_q <= 1'b0;
        end
        else
        begin
            rdActive_q <= rdActive;
            wrActive_q <= wrActive;
            rdOe_q <= rdActive;
            if (rdStart)
                rdData_q <= readValue;
        end
    end

    // registered configuration outputs
    logic [4:0] cfgOut_q;
    logic [7:0] txQueue_q;
    logic [7:0] rxQueue_q;
    logic fullDuplex_q;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cfgOut_q <= '0;
            txQueue_q <= RESET_BYTE;
            rxQueue_q <= RESET_BYTE;
            fullDuplex_q <= 1'b1;
        end
        else
        begin
            cfgOut_q <= effCfg;
            txQueue_q <= effTxQueue;
            rxQueue_q <= effRxQueue;
            fullDuplex_q <= strapMode_q ? strapDuplex_q : 1'b1;
        end
    end

    assign hostDataOut = rdData_q;
    assign hostDataOe = rdOe_q;
    assign cfgStrapped = strapMode_q;
    assign cfgLapsEncap = cfgOut_q[CFG_LAPS];
    assign cfgScramblerBypass = cfgOut_q[CFG_SCR_BYPASS];
    assign cfgBitOrderReverse = cfgOut_q[CFG_BIT_REVERSE];
    assign cfgReducedInterface = cfgOut_q[CFG_REDUCED];
    assign cfgLineRoleDce = cfgOut_q[CFG_LINE_ROLE];
    assign cfgFullDuplex = fullDuplex_q;
    assign cfgTxQueueSize = txQueue_q;
    assign cfgRxQueueSize = rxQueue_q;
    assign softReset = globalRegs_q[OFS_GLOBAL_CONTROL_ONE][BIT_RESET];
    assign globalControl = globalRegs_q[OFS_GLOBAL_CONTROL_ONE];
    assign macReq = macReq_q;
    assign macWrite = macWrite_q;
    assign macAddr = macAddr_q;
    assign macWrData = macWrData_q;
endmodule

// *** strap_regmap_pkg.sv ***
package strap_regmap_pkg;
    // host bus and section layout
    localparam int ADDR_W = 10;
    localparam int DATA_W = 8;
    localparam int SYNC_W = 3 + ADDR_W + DATA_W + 9;
    localparam logic [ADDR_W-1:0] SEC_MASK = 10'h3c0;
    localparam logic [ADDR_W-1:0] SEC_GLOBAL = 10'h000;
    localparam logic [ADDR_W-1:0] SEC_ARBITER = 10'h040;
    localparam logic [ADDR_W-1:0] SEC_BERT = 10'h080;
    localparam logic [ADDR_W-1:0] SEC_SERIAL_LO = 10'h0c0;
    localparam logic [ADDR_W-1:0] SEC_ETHERNET = 10'h140;
    localparam logic [ADDR_W-1:0] UNUSED_BASE = 10'h180;
    localparam int SEC_DEPTH = 64;

    // global section offsets
    localparam logic [5:0] OFS_ID_LOW = 6'h00;
    localparam logic [5:0] OFS_ID_HIGH = 6'h01;
    localparam logic [5:0] OFS_GLOBAL_CONTROL_ONE = 6'h02;
    localparam logic [5:0] OFS_GLOBAL_BANK_LATCH = 6'h03;
    localparam logic [5:0] OFS_LINE_CLOCK_ACTIVITY = 6'h04;
    localparam logic [5:0] OFS_REF_SYS_CLOCK_ACTIVITY = 6'h05;
    localparam logic [5:0] OFS_LINE_IRQ_ENABLE = 6'h06;
    localparam logic [5:0] OFS_LINE_IRQ_STATUS = 6'h07;
    localparam logic [5:0] OFS_SUBSCRIBER_IRQ_ENABLE = 6'h08;
    localparam logic [5:0] OFS_SUBSCRIBER_IRQ_STATUS = 6'h09;
    localparam logic [5:0] OFS_QUEUE_IRQ_ENABLE = 6'h0a;
    localparam logic [5:0] OFS_QUEUE_IRQ_STATUS = 6'h0b;
    localparam logic [5:0] OFS_BERT_IRQ_ENABLE = 6'h0c;
    localparam logic [5:0] OFS_BERT_IRQ_STATUS = 6'h0d;
    localparam logic [5:0] OFS_GLOBAL_CONNECTION = 6'h0e;
    localparam logic [5:0] OFS_QUEUE_PRIORITY_CONTROL = 6'h12;
    localparam logic [5:0] OFS_STRAP_SHADOW_CONFIG = 6'h13;
    localparam logic [5:0] OFS_SELF_TEST_ENABLE = 6'h20;
    localparam logic [5:0] OFS_SELF_TEST_RESULT = 6'h21;
    localparam logic [5:0] OFS_SDRAM_MODE_ONE = 6'h3a;
    localparam logic [5:0] OFS_SDRAM_MODE_TWO = 6'h3b;
    localparam logic [5:0] OFS_SDRAM_MODE_WRITE_STROBE = 6'h3c;
    localparam logic [5:0] OFS_SDRAM_REFRESH_COUNT = 6'h3d;
    // arbiter section offsets
    localparam logic [5:0] OFS_RX_QUEUE_SIZE = 6'h00;
    localparam logic [5:0] OFS_TX_QUEUE_SIZE = 6'h01;
    // ethernet section: indirect mac access window
    localparam logic [5:0] OFS_MAC_ADDR_LOW = 6'h00;
    localparam logic [5:0] OFS_MAC_ADDR_HIGH = 6'h01;
    localparam logic [5:0] OFS_MAC_DATA = 6'h02;
    localparam logic [5:0] OFS_MAC_COMMAND = 6'h03;
    localparam logic [5:0] OFS_MAC_READ_DATA = 6'h04;

    // implemented bits of each register
    localparam logic [7:0] MASK_CONTROL_ONE = 8'h07;
    localparam logic [7:0] MASK_BIT0 = 8'h01;
    localparam logic [7:0] MASK_BITS_4_0 = 8'h11;
    localparam logic [7:0] MASK_PRIORITY = 8'h0f;
    localparam logic [7:0] MASK_SHADOW = 8'h1f;
    localparam logic [7:0] MASK_SELF_TEST = 8'h03;
    localparam logic [7:0] MASK_SDRAM_ONE = 8'h0f;
    localparam logic [7:0] MASK_SDRAM_TWO = 8'h07;
    localparam logic [7:0] MASK_ALL = 8'hff;
    localparam logic [7:0] MASK_MAC_CMD = 8'h03;

    // field positions
    localparam int BIT_RESET = 0;
    localparam int CFG_LAPS = 0;
    localparam int CFG_SCR_BYPASS = 1;
    localparam int CFG_BIT_REVERSE = 2;
    localparam int CFG_REDUCED = 3;
    localparam int CFG_LINE_ROLE = 4;
    localparam int CMD_WRITE = 0;
    localparam int CMD_READ = 1;

    // strap profiles and their queue sizes
    localparam logic [1:0] PROFILE_A = 2'h0;
    localparam logic [1:0] PROFILE_B = 2'h2;
    localparam logic [7:0] TX_QUEUE_PROFILE_A = 8'h14;
    localparam logic [7:0] TX_QUEUE_PROFILE_B = 8'h18;
    localparam logic [7:0] RX_QUEUE_PROFILE_A = 8'h2c;
    localparam logic [7:0] RX_QUEUE_PROFILE_B = 8'h28;

    // edges after reset release before straps are caught
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
endpackage

// *** strap_regmap_props.sv ***
module strap_regmap_props
    import strap_regmap_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic hostCsN,
    input wire logic hostRdN,
    input wire logic hostWrN,
    input wire logic hostDataOe,
    input wire logic cfgStrapped,
    input wire logic cfgLapsEncap,
    input wire logic cfgScramblerBypass,
    input wire logic cfgBitOrderReverse,
    input wire logic cfgReducedInterface,
    input wire logic cfgLineRoleDce,
    input wire logic cfgFullDuplex,
    input wire logic [7:0] cfgTxQueueSize,
    input wire logic [7:0] cfgRxQueueSize,
    input wire logic softReset,
    input wire logic [7:0] globalControl,
    input wire logic macReq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // cfg outputs trail cfgStrapped by one edge, so wait for three samples
    sequence s_strap_held;
        cfgStrapped && $past(cfgStrapped) && $past(cfgStrapped, 2);
    endsequence
    sequence s_read_idle;
        hostRdN [*4];
    endsequence

    property p_cfg_frozen;
        s_strap_held |-> $stable({cfgLapsEncap, cfgScramblerBypass, cfgBitOrderReverse,
            cfgReducedInterface, cfgLineRoleDce, cfgTxQueueSize, cfgRxQueueSize});
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen) else $error("strap config moved");
    property p_queue_profile;
        s_strap_held |-> (cfgTxQueueSize == TX_QUEUE_PROFILE_A && cfgRxQueueSize == RX_QUEUE_PROFILE_A)
            || (cfgTxQueueSize == TX_QUEUE_PROFILE_B && cfgRxQueueSize == RX_QUEUE_PROFILE_B);
    endproperty
    a_queue_profile: assert property (p_queue_profile) else $error("bad strap queue size");
    property p_duplex_free;
        !cfgStrapped && $past(!cfgStrapped) |-> cfgFullDuplex;
    endproperty
    a_duplex_free: assert property (p_duplex_free) else $error("duplex low in register mode");
    property p_oe_cause;
        $rose(hostDataOe) |-> $past(!hostCsN && !hostRdN, 2);
    endproperty
    a_oe_cause: assert property (p_oe_cause) else $error("data driven without read");
    property p_oe_release;
        s_read_idle |-> !hostDataOe;
    endproperty
    a_oe_release: assert property (p_oe_release) else $error("data still driven");
    property p_mac_pulse;
        macReq |=> !macReq;
    endproperty
    a_mac_pulse: assert property (p_mac_pulse) else $error("mac request too long");
    property p_soft_reset;
        softReset == globalControl[BIT_RESET] && (globalControl & ~MASK_CONTROL_ONE) == 8'h00;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("control bits wrong");
    property p_ctrl_by_write;
        $changed(globalControl) |-> $past(!hostCsN && !hostWrN, 2);
    endproperty
    a_ctrl_by_write: assert property (p_ctrl_by_write) else $error("control moved unwritten");
endmodule

bind strap_config_and_register_map strap_regmap_props u_props (.clk, .resetn, .hostCsN, .hostRdN,
    .hostWrN, .hostDataOe, .cfgStrapped, .cfgLapsEncap, .cfgScramblerBypass, .cfgBitOrderReverse,
    .cfgReducedInterface, .cfgLineRoleDce, .cfgFullDuplex, .cfgTxQueueSize, .cfgRxQueueSize,
    .softReset, .globalControl, .macReq);

// *** mac_side_model.sv ***
module mac_side_model
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic slow,
    input wire logic macReq,
    input wire logic macWrite,
    input wire logic [15:0] macAddr,
    output logic [7:0] macReadData,
    output logic macReadValid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] waitCnt;

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            waitCnt <= 4'h0;
            macReadValid <= 1'b0;
            macReadData <= 8'h00;
        end
        else
        begin
            macReadValid <= 1'b0;
            // stale data toggles so it never passes for a reply
            macReadData <= ~macReadData;
            if (waitCnt != 4'h0)
                waitCnt <= waitCnt - 4'h1;
            if (macReq && !macWrite)
                waitCnt <= slow ? 4'h8 : 4'h1;
            if (waitCnt == 4'h1)
            begin
                macReadValid <= 1'b1;
                macReadData <= macAddr[7:0] ^ 8'h5a;
            end
        end
    end
endmodule

// *** strap_config_and_register_map_tb.sv ***
module strap_config_and_register_map_tb
    import strap_regmap_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] TB_ID = 16'h3c71;  // arbitrary value
    logic clk = 1'b0, resetn = 1'b0, hostCsN = 1'b1, hostRdN = 1'b1, hostWrN = 1'b1, slow = 1'b0;
    logic [ADDR_W-1:0] hostAddr = 10'h000;
    logic [7:0] hostDataIn = 8'h00, act = 8'hff, evt = 8'h00;
    logic strap_config_enable = 1'b0;
    logic [1:0] profileSelect = 2'h0, selfTestResult = 2'h3;
    logic [4:0] straps = 5'h00;
    logic [7:0] hostDataOut, macReadData, cfgTxQueueSize, cfgRxQueueSize, globalControl, macWrData;
    logic hostDataOe, macReadValid, cfgStrapped, cfgLapsEncap, cfgScramblerBypass, cfgBitOrderReverse;
    logic cfgReducedInterface, cfgLineRoleDce, cfgFullDuplex, softReset, macReq, macWrite;
    logic [15:0] macAddr, macAddrSeen;
    logic [7:0] macDataSeen;
    logic macWriteSeen;
    int mismatches = 0, check_count = 0, macCount = 0;
    wire logic [4:0] cfgVec = {cfgLineRoleDce, cfgReducedInterface, cfgBitOrderReverse, cfgScramblerBypass,
        cfgLapsEncap};

    strap_config_and_register_map #(.DEVICE_ID(TB_ID)) dut (.clk, .resetn, .hostCsN, .hostRdN, .hostWrN,
        .hostAddr, .hostDataIn, .hostDataOut, .hostDataOe, .strap_config_enable, .profileSelect,
        .reduced_interface_select(straps[3]), .line_role_select(straps[4]), .full_duplex_strap(1'b1),
        .laps_encap_enable(straps[0]), .scrambler_bypass(straps[1]), .bit_order_reverse(straps[2]),
        .lineClockActivity(act), .refSysClockActivity(act), .lineEvents(evt), .subscriberEvents(evt),
        .queueEvents(evt), .bertEvents(evt), .selfTestResult, .macReadData, .macReadValid, .cfgStrapped,
        .cfgLapsEncap, .cfgScramblerBypass, .cfgBitOrderReverse, .cfgReducedInterface, .cfgLineRoleDce,
        .cfgFullDuplex, .cfgTxQueueSize, .cfgRxQueueSize, .softReset, .globalControl, .macReq, .macWrite,
        .macAddr, .macWrData);
    mac_side_model partner (.clk, .resetn, .slow, .macReq, .macWrite, .macAddr, .macReadData, .macReadValid);

    always #12.5 clk = ~clk;

    always @(posedge clk)
        if (macReq === 1'b1)
        begin
            macCount <= macCount + 1;
            macWriteSeen <= macWrite;
            macAddrSeen <= macAddr;
            macDataSeen <= macWrData;
        end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask

    task automatic do_reset();
        @(posedge clk);
        #1 resetn = 1'b0;
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        repeat (8) @(posedge clk);
        #1;
    endtask

    // address settles three clocks before the strobe, strobe held until data is driven on reads, eight clocks on writes
    task automatic access(input logic [9:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
        int n;
        hostAddr = a;
        hostDataIn = d;
        repeat (3) @(posedge clk);
        #1 hostCsN = 1'b0;
        hostRdN = wr;
        hostWrN = !wr;
        for (n = 0; n < 8; n++)
        begin
            @(posedge clk);
            #1;
            if (!wr && hostDataOe === 1'b1)
                break;
        end
        if (!wr && n == 8)
        begin
            mismatches++;
            final_report();
        end
        q = hostDataOut;
        hostCsN = 1'b1;
        hostRdN = 1'b1;
        hostWrN = 1'b1;
        repeat (5) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(a, 1'b1, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [9:0] a, input logic [7:0] exp);
        logic [7:0] q;
        access(a, 1'b0, 8'h00, q);
        chk(name, exp, q);
    endtask

    task automatic t_identity();
        rd_chk("id_low", 10'h000, TB_ID[7:0]);
        wr(10'h001, 8'hff);
        rd_chk("id_high", 10'h001, TB_ID[15:8]);
    endtask

    task automatic t_strap(input logic [1:0] prof, input logic [4:0] pins);
        logic [7:0] tx, rx;
        tx = (prof == PROFILE_B) ? TX_QUEUE_PROFILE_B : TX_QUEUE_PROFILE_A;
        rx = (prof == PROFILE_B) ? RX_QUEUE_PROFILE_B : RX_QUEUE_PROFILE_A;
        strap_config_enable = 1'b1;
        profileSelect = prof;
        straps = pins;
        do_reset();
        chk("strapped", 16'h1, cfgStrapped);
        chk("cfg", pins, cfgVec);
        chk("tx_size", tx, cfgTxQueueSize);
        rd_chk("rx_reg", 10'h040, rx);
        straps = ~pins;
        profileSelect = ~prof;
        repeat (10) @(posedge clk);
        #1 chk("held", pins, cfgVec);
        chk("tx_held", tx, cfgTxQueueSize);
    endtask

    task automatic t_regmode();
        strap_config_enable = 1'b0;
        straps = 5'h00;
        do_reset();
        chk("not_strapped", 16'h0, cfgStrapped);
        chk("duplex", 16'h1, cfgFullDuplex);
        wr(10'h013, 8'h1f);
        rd_chk("shadow", 10'h013, MASK_SHADOW);
        chk("cfg_reg", 16'h1f, cfgVec);
        wr(10'h041, 8'h5a);
        rd_chk("tx_reg", 10'h041, 8'h5a);
        chk("tx_cfg", 16'h5a, cfgTxQueueSize);
    endtask

    task automatic t_reserved();
        wr(10'h002, 8'h06);
        rd_chk("control", 10'h002, 8'h06);
        chk("global", 16'h06, globalControl);
        wr(10'h082, 8'h01);
        wr(10'h0c2, 8'h01);
        wr(10'h202, 8'h00);
        rd_chk("no_alias", 10'h002, 8'h06);
        chk("soft_reset", 16'h0, softReset);
        wr(10'h012, 8'h0f);
        rd_chk("priority", 10'h012, MASK_PRIORITY);
        wr(10'h200, 8'h00);
        rd_chk("unused", 10'h200, 8'h00);
    endtask

    task automatic t_status();
        logic [9:0] adr [7] = '{10'h004, 10'h005, 10'h007, 10'h009, 10'h00b, 10'h00d, 10'h021};
        logic [7:0] ex [7] = '{8'h11, 8'h03, MASK_BITS_4_0, MASK_BIT0, MASK_BITS_4_0, MASK_BIT0, 8'h03};
        evt = 8'hff;
        @(posedge clk);
        #1 evt = 8'h00;
        for (int i = 0; i < 7; i++)
        begin
            rd_chk("status", adr[i], ex[i]);
            rd_chk("status_again", adr[i], (i >= 2 && i <= 5) ? 8'h00 : ex[i]);
        end
    endtask

    task automatic t_mac();
        wr(10'h140, 8'h34);
        wr(10'h141, 8'h12);
        wr(10'h142, 8'ha5);
        wr(10'h143, 8'h01);
        chk("mac_write", 16'h0180, {macCount[7:0], macWriteSeen, 7'h0});
        chk("mac_addr", 16'h1234, macAddrSeen);
        chk("mac_data", 16'ha5, macDataSeen);
        wr(10'h143, 8'h02);
        rd_chk("mac_read", 10'h144, 8'h34 ^ 8'h5a);
        slow = 1'b1;
        wr(10'h140, 8'h77);
        wr(10'h143, 8'h02);
        rd_chk("mac_slow", 10'h144, 8'h77 ^ 8'h5a);
        chk("mac_count", 16'h3, macCount[15:0]);
    endtask

    initial
    begin
        do_reset();
        t_identity();
        t_strap(PROFILE_A, 5'h15);
        t_strap(PROFILE_B, 5'h0a);
        t_strap(2'h1, 5'h1f);
        t_regmode();
        t_reserved();
        t_status();
        t_mac();
        final_report();
    end
endmodule
